// *** timer_pkg.sv ***
package timer_pkg;
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_MODE   = 4'h1;
    localparam logic [3:0] ADDR_A_LOW  = 4'h2;
    localparam logic [3:0] ADDR_A_HIGH = 4'h3;
    localparam logic [3:0] ADDR_B_LOW  = 4'h4;
    localparam logic [3:0] ADDR_B_HIGH = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam logic [3:0] ADDR_MASK   = 4'h7;

    // control register fields
    localparam int CTRL_B_OVF  = 7;
    localparam int CTRL_B_RUN  = 6;
    localparam int CTRL_A_OVF  = 5;
    localparam int CTRL_A_RUN  = 4;
    localparam int CTRL_B_EDGE = 3;
    localparam int CTRL_B_TYPE = 2;
    localparam int CTRL_A_EDGE = 1;
    localparam int CTRL_A_TYPE = 0;

    // mode register fields, per-unit nibble
    localparam int MODE_B_BASE = 4;
    localparam int MODE_A_BASE = 0;
    localparam int MODE_GATE   = 3;
    localparam int MODE_FUNC   = 2;
    localparam int MODE_HI     = 1;
    localparam int MODE_LO     = 0;

    // status / mask bits
    localparam int ST_A_OVF  = 0;
    localparam int ST_B_OVF  = 1;
    localparam int ST_A_EDGE = 2;
    localparam int ST_B_EDGE = 3;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    localparam logic [1:0] MODE_13BIT  = 2'h0;
    localparam logic [1:0] MODE_16BIT  = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT  = 2'h3;

    // clocks per machine cycle
    localparam int          MC_CLOCKS = 12;
    localparam logic [3:0]  MC_LAST   = 4'hB;
endpackage

// *** timer_unit.sv ***
`timescale 1ns/10ps
module timer_unit
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // controls
    input  wire logic       tick,
    input  wire logic       pin_fall,
    input  wire logic       run,
    input  wire logic       gate,
    input  wire logic       irq_pin,
    input  wire logic       func,
    input  wire logic [1:0] mode,
    input  wire logic       split_a,
    input  wire logic       hold_b,
    // software write
    input  wire logic       wr_low,
    input  wire logic       wr_high,
    input  wire logic [7:0] wdata,
    // split high byte controls
    input  wire logic       hi_run,
    // state
    output logic      [7:0] low_q,
    output logic      [7:0] high_q,
    output logic            ovf,
    output logic            hi_ovf
);
    logic [7:0] low_d;
    logic [7:0] high_d;
    wire        enable = run && (!gate || irq_pin) && !hold_b;
    wire        step   = enable && (func ? pin_fall : tick);
    wire        hi_step = split_a && hi_run && tick;
    wire [4:0]  pre_nx = low_q[4:0] + 5'h01;
    wire [8:0]  lo_nx  = {1'b0, low_q} + 9'h001;
    wire [8:0]  hi_nx  = {1'b0, high_q} + 9'h001;
    wire        pre_wrap = low_q[4:0] == 5'h1F;
    wire        m13 = mode == timer_pkg::MODE_13BIT;
    wire        m16 = mode == timer_pkg::MODE_16BIT;
    wire        mrl = mode == timer_pkg::MODE_RELOAD;
    wire        msp = mode == timer_pkg::MODE_SPLIT;

    assign ovf = step && ((m13 && pre_wrap && high_q == 8'hFF)
                       || (m16 && low_q == 8'hFF && high_q == 8'hFF)
                       || ((mrl || msp) && low_q == 8'hFF));
    assign hi_ovf = hi_step && high_q == 8'hFF;

    always_comb
    begin
        low_d  = low_q;
        high_d = high_q;
        if (step && m13)
        begin
            // upper three low bits left as they are, never meaningful
            low_d = {low_q[7:5], pre_nx};
            if (pre_wrap)
                high_d = hi_nx[7:0];
        end
        else if (step && m16)
        begin
            low_d = lo_nx[7:0];
            if (low_q == 8'hFF)
                high_d = hi_nx[7:0];
        end
        else if (step && mrl)
            low_d = (low_q == 8'hFF) ? high_q : lo_nx[7:0];
        else if (step && msp)
            low_d = lo_nx[7:0];
        if (hi_step)
            high_d = hi_nx[7:0];
        if (wr_low)
            low_d = wdata;
        if (wr_high)
            high_d = wdata;
    end

    // run bit touches no count byte
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            low_q  <= timer_pkg::COUNT_RESET;
            high_q <= timer_pkg::COUNT_RESET;
        end
        else
        begin
            low_q  <= low_d;
            high_q <= high_d;
        end
    end
endmodule

// *** dual_timer_counter_unit.sv ***
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module dual_timer_counter_unit
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // register port
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // pins
    input  wire logic       unit_a_event_pin,
    input  wire logic       unit_b_event_pin,
    input  wire logic       ext_irq_a_pin,
    input  wire logic       ext_irq_b_pin,
    // core vector acknowledges
    input  wire logic       ack_unit_a,
    input  wire logic       ack_unit_b,
    input  wire logic       ack_ext_a,
    input  wire logic       ack_ext_b,
    // requests to the core
    output logic            req_unit_a,
    output logic            req_unit_b,
    output logic            req_ext_a,
    output logic            req_ext_b,
    output logic            irq
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0]
    {
        PH_SAMPLE = 2'h1,
        PH_WAIT   = 2'h2
    } phase_e;

    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] mode_q;
    logic [3:0] status_q;
    logic [3:0] status_d;
    logic [3:0] mask_q;
    logic [7:0] rdata_d;
    logic [3:0] mc_cnt_q;
    phase_e     phase_q;
    logic       tick_q;
    logic [1:0] ev_last_q;
    logic [1:0] ev_fall_q;
    logic [1:0] irq_last_q;
    logic       irq_q;
    logic       req_a_q;
    logic       req_b_q;
    logic       req_ea_q;
    logic       req_eb_q;
    logic [7:0] a_low;
    logic [7:0] a_high;
    logic [7:0] b_low;
    logic [7:0] b_high;
    logic       a_ovf;
    logic       a_hi_ovf;
    logic       b_ovf;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = a == r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decode
    wire        wr_ctrl = wr && hit(addr, timer_pkg::ADDR_CTRL);
    wire        wr_mode = wr && hit(addr, timer_pkg::ADDR_MODE);
    wire        wr_mask = wr && hit(addr, timer_pkg::ADDR_MASK);
    wire        rd_stat = rd && hit(addr, timer_pkg::ADDR_STATUS);
    wire [3:0]  mode_a  = mode_q[timer_pkg::MODE_A_BASE +: 4];
    wire [3:0]  mode_b  = mode_q[timer_pkg::MODE_B_BASE +: 4];
    wire [1:0]  mfa     = mode_a[timer_pkg::MODE_HI:timer_pkg::MODE_LO];
    wire [1:0]  mfb     = mode_b[timer_pkg::MODE_HI:timer_pkg::MODE_LO];
    wire        split   = mfa == timer_pkg::MODE_SPLIT;
    wire        b_stop  = mfb == timer_pkg::MODE_SPLIT;
    wire        run_a   = ctrl_q[timer_pkg::CTRL_A_RUN];
    wire        run_b   = ctrl_q[timer_pkg::CTRL_B_RUN];
    wire        type_a  = ctrl_q[timer_pkg::CTRL_A_TYPE];
    wire        type_b  = ctrl_q[timer_pkg::CTRL_B_TYPE];
    wire [1:0]  irq_now = {ext_irq_b_pin, ext_irq_a_pin};
    wire [1:0]  irq_fall = tick_q ? (irq_last_q & ~irq_now) : 2'h0;
    // falling edge latches when type set, a low level when clear
    wire        ea_set = type_a ? irq_fall[0] : (tick_q && !irq_now[0]);
    wire        eb_set = type_b ? irq_fall[1] : (tick_q && !irq_now[1]);
    // in split mode unit a's high byte owns unit b's flag
    wire        set_b_ovf = split ? a_hi_ovf : b_ovf;

    ////////////////////////////////////////////////////////////////////////
    // machine cycle: one tick every twelve clocks; sample-then-use phase
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mc_cnt_q <= 4'h0;
            tick_q   <= 1'b0;
            phase_q  <= PH_WAIT;
        end
        else
        begin
            mc_cnt_q <= (mc_cnt_q == timer_pkg::MC_LAST) ? 4'h0
                                                         : mc_cnt_q + 4'h1;
            tick_q   <= mc_cnt_q == timer_pkg::MC_LAST;
            phase_q  <= (mc_cnt_q == timer_pkg::MC_LAST) ? PH_SAMPLE
                                                         : PH_WAIT;
        end
    end

    // pins sampled once per machine cycle, high then low counts one
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_pin
            wire ev_now = gi == 0 ? unit_a_event_pin : unit_b_event_pin;
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    ev_last_q[gi]  <= 1'b0;
                    ev_fall_q[gi]  <= 1'b0;
                    irq_last_q[gi] <= 1'b1;
                end
                else
                begin
                    case (phase_q)
                        PH_SAMPLE:
                        begin
                            ev_fall_q[gi] <= ev_last_q[gi] && !ev_now;
                            ev_last_q[gi] <= ev_now;
                        end
                        PH_WAIT:
                            ev_fall_q[gi] <= ev_fall_q[gi];
                        default:
                            ev_fall_q[gi] <= 1'b0;
                    endcase
                    if (tick_q)
                        irq_last_q[gi] <= irq_now[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    timer_unit u_a
    (
        .clk     (clk),
        .arst_n  (arst_n),
        .tick    (tick_q),
        .pin_fall(ev_fall_q[0] && tick_q),
        .run     (run_a),
        .gate    (mode_a[timer_pkg::MODE_GATE]),
        .irq_pin (ext_irq_a_pin),
        .func    (mode_a[timer_pkg::MODE_FUNC]),
        .mode    (mfa),
        .split_a (split),
        .hold_b  (1'b0),
        .wr_low  (wr && hit(addr, timer_pkg::ADDR_A_LOW)),
        .wr_high (wr && hit(addr, timer_pkg::ADDR_A_HIGH)),
        .wdata   (wdata),
        .hi_run  (run_b),
        .low_q   (a_low),
        .high_q  (a_high),
        .ovf     (a_ovf),
        .hi_ovf  (a_hi_ovf)
    );

    timer_unit u_b
    (
        .clk     (clk),
        .arst_n  (arst_n),
        .tick    (tick_q),
        .pin_fall(ev_fall_q[1] && tick_q),
        .run     (run_b),
        .gate    (mode_b[timer_pkg::MODE_GATE]),
        .irq_pin (ext_irq_b_pin),
        .func    (mode_b[timer_pkg::MODE_FUNC]),
        .mode    (mfb),
        .split_a (1'b0),
        .hold_b  (b_stop),
        .wr_low  (wr && hit(addr, timer_pkg::ADDR_B_LOW)),
        .wr_high (wr && hit(addr, timer_pkg::ADDR_B_HIGH)),
        .wdata   (wdata),
        .hi_run  (1'b0),
        .low_q   (b_low),
        .high_q  (b_high),
        .ovf     (b_ovf),
        .hi_ovf  ()
    );

    ////////////////////////////////////////////////////////////////////////
    // control register: hardware sets win over software or acknowledge
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_ctrl)
            ctrl_d = wdata;
        if (ack_unit_a)
            ctrl_d[timer_pkg::CTRL_A_OVF] = 1'b0;
        if (ack_unit_b)
            ctrl_d[timer_pkg::CTRL_B_OVF] = 1'b0;
        if (ack_ext_a)
            ctrl_d[timer_pkg::CTRL_A_EDGE] = 1'b0;
        if (ack_ext_b)
            ctrl_d[timer_pkg::CTRL_B_EDGE] = 1'b0;
        if (a_ovf)
            ctrl_d[timer_pkg::CTRL_A_OVF] = 1'b1;
        if (set_b_ovf)
            ctrl_d[timer_pkg::CTRL_B_OVF] = 1'b1;
        if (ea_set)
            ctrl_d[timer_pkg::CTRL_A_EDGE] = 1'b1;
        if (eb_set)
            ctrl_d[timer_pkg::CTRL_B_EDGE] = 1'b1;
    end

    wire [3:0] ev_vec = {eb_set, ea_set, set_b_ovf, a_ovf};

    always_comb
    begin
        status_d = rd_stat ? ev_vec : (status_q | ev_vec);
    end

    always_comb
    begin
        case (addr)
            timer_pkg::ADDR_CTRL:   rdata_d = ctrl_q;
            timer_pkg::ADDR_MODE:   rdata_d = mode_q;
            timer_pkg::ADDR_A_LOW:  rdata_d = a_low;
            timer_pkg::ADDR_A_HIGH: rdata_d = a_high;
            timer_pkg::ADDR_B_LOW:  rdata_d = b_low;
            timer_pkg::ADDR_B_HIGH: rdata_d = b_high;
            timer_pkg::ADDR_STATUS: rdata_d = {4'h0, status_q};
            timer_pkg::ADDR_MASK:   rdata_d = {4'h0, mask_q};
            default:                rdata_d = 8'h00;
        endcase
    end

    wire [3:0] ctl_flags = {ctrl_d[timer_pkg::CTRL_B_EDGE],
                            ctrl_d[timer_pkg::CTRL_A_EDGE],
                            ctrl_d[timer_pkg::CTRL_B_OVF],
                            ctrl_d[timer_pkg::CTRL_A_OVF]};

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q   <= timer_pkg::CTRL_RESET;
            mode_q   <= timer_pkg::MODE_RESET;
            status_q <= 4'h0;
            mask_q   <= 4'h0;
            rdata    <= 8'h00;
            irq_q    <= 1'b0;
            req_a_q  <= 1'b0;
            req_b_q  <= 1'b0;
            req_ea_q <= 1'b0;
            req_eb_q <= 1'b0;
        end
        else
        begin
            ctrl_q   <= ctrl_d;
            if (wr_mode)
                mode_q <= wdata;
            if (wr_mask)
                mask_q <= wdata[3:0];
            status_q <= status_d;
            rdata    <= rd ? rdata_d : 8'h00;
            irq_q    <= |(status_d & mask_q);
            req_a_q  <= ctl_flags[0];
            req_b_q  <= ctl_flags[1];
            req_ea_q <= ctl_flags[2];
            req_eb_q <= ctl_flags[3];
        end
    end

    assign req_unit_a = req_a_q;
    assign req_unit_b = req_b_q;
    assign req_ext_a  = req_ea_q;
    assign req_ext_b  = req_eb_q;
    assign irq        = irq_q;
endmodule

// *** timer_props.sv ***
`timescale 1ns/10ps
module timer_props
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // register port
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    input  wire logic [7:0] rdata,
    // vectoring
    input  wire logic       ack_unit_a,
    input  wire logic       ack_unit_b,
    input  wire logic       ack_ext_a,
    input  wire logic       req_unit_a,
    input  wire logic       req_unit_b,
    input  wire logic       req_ext_a,
    input  wire logic       req_ext_b,
    input  wire logic       irq
);
    logic [7:0] mode_sh_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // mirror of the mode register, kept only to judge read-back
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            mode_sh_q <= timer_pkg::MODE_RESET;
        else if (wr && addr == timer_pkg::ADDR_MODE)
            mode_sh_q <= wdata;
    end

    ////////////////////////////////////////////////////////////////////////
    property p_rdata_idle;
        !$past(rd) |-> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("rdata not zero outside a read answer");
    property p_mode_read;
        $past(rd && addr == timer_pkg::ADDR_MODE) |-> rdata == mode_sh_q;
    endproperty
    a_mode_read: assert property (p_mode_read)
        else $error("mode register read-back differs");
    property p_unmapped;
        $past(rd && addr[3]) |-> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_ack_a;
        $fell(req_unit_a) |-> $past(ack_unit_a) || $past(wr);
    endproperty
    a_ack_a: assert property (p_ack_a)
        else $error("unit a flag dropped without acknowledge");
    property p_ack_b;
        $fell(req_unit_b) |-> $past(ack_unit_b) || $past(wr);
    endproperty
    a_ack_b: assert property (p_ack_b)
        else $error("unit b flag dropped without acknowledge");
    property p_ack_ext;
        $fell(req_ext_a) |-> $past(ack_ext_a) || $past(wr);
    endproperty
    a_ack_ext: assert property (p_ack_ext)
        else $error("ext a flag dropped without acknowledge");
    property p_irq_rise;
        $rose(irq) |-> req_unit_a || req_unit_b || req_ext_a || req_ext_b
            || $past(wr, 2);
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("irq rose with no event");
    property p_irq_fall;
        // a status read drops irq at once, a mask write one cycle later
        $fell(irq) |-> $past(rd) || $past(wr, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq fell with no read or mask write");
endmodule

bind dual_timer_counter_unit timer_props chk_u
    (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .ack_unit_a,
     .ack_unit_b, .ack_ext_a, .req_unit_a, .req_unit_b, .req_ext_a,
     .req_ext_b, .irq);

// *** core_vector_model.sv ***
`timescale 1ns/10ps
module core_vector_model
(
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // behaviour controls
    input  wire logic en,
    input  wire logic slow,
    // requests from the timers
    input  wire logic req_unit_a,
    input  wire logic req_unit_b,
    input  wire logic req_ext_a,
    input  wire logic req_ext_b,
    // vector acknowledges
    output logic      ack_unit_a,
    output logic      ack_unit_b,
    output logic      ack_ext_a,
    output logic      ack_ext_b
);
    logic [3:0] wait_q;
    wire  logic [3:0] pick;

    // fixed priority; the reload after a pulse outlasts the flag's fall
    assign pick = req_ext_a ? 4'h1 : req_unit_a ? 4'h2 :
                  req_ext_b ? 4'h4 : req_unit_b ? 4'h8 : 4'h0;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wait_q <= 4'h0;
            {ack_unit_b, ack_ext_b, ack_unit_a, ack_ext_a} <= 4'h0;
        end
        else
        begin
            {ack_unit_b, ack_ext_b, ack_unit_a, ack_ext_a} <= 4'h0;
            if (!en || pick == 4'h0 || wait_q == 4'h0)
                wait_q <= slow ? 4'h9 : 4'h3;
            else
                wait_q <= wait_q - 4'h1;
            if (en && pick != 4'h0 && wait_q == 4'h1)
                {ack_unit_b, ack_ext_b, ack_unit_a, ack_ext_a} <= pick;
        end
    end
endmodule

// *** dual_timer_counter_unit_test.sv ***
`timescale 1ns/10ps
module dual_timer_counter_unit_test;
    localparam logic [3:0] CTL = timer_pkg::ADDR_CTRL;
    localparam logic [3:0] MDE = timer_pkg::ADDR_MODE;
    localparam logic [3:0] STS = timer_pkg::ADDR_STATUS;
    localparam logic [3:0] MSK = timer_pkg::ADDR_MASK;
    logic        clk, arst_n, wr, rd, en, slow, rd_seen;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic        unit_a_event_pin, unit_b_event_pin;
    logic        ext_irq_a_pin, ext_irq_b_pin;
    wire  logic [7:0] rdata;
    wire  logic  irq, req_unit_a, req_unit_b, req_ext_a, req_ext_b;
    wire  logic  ack_unit_a, ack_unit_b, ack_ext_a, ack_ext_b;
    wire  logic [3:0] reqs = {req_ext_b, req_ext_a, req_unit_b, req_unit_a};
    logic [15:0] exp_q[$];
    logic [15:0] e;
    logic [31:0] seed = 32'hF8F8;
    int          err_total = 0;
    int          n_checks = 0;

    dual_timer_counter_unit dut_u (.clk, .arst_n, .addr, .wdata, .wr, .rd,
        .rdata, .unit_a_event_pin, .unit_b_event_pin, .ext_irq_a_pin,
        .ext_irq_b_pin, .ack_unit_a, .ack_unit_b, .ack_ext_a, .ack_ext_b,
        .req_unit_a, .req_unit_b, .req_ext_a, .req_ext_b, .irq);
    core_vector_model cpu_u (.clk, .arst_n, .en, .slow, .req_unit_a,
        .req_unit_b, .req_ext_a, .req_ext_b, .ack_unit_a, .ack_unit_b,
        .ack_ext_a, .ack_ext_b);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task conclude;
        if (err_total == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task cmp(input string what, input logic [7:0] x, input logic [7:0] s);
        n_checks++;
        if (s !== x)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, x, s);
        end
    endtask

    // strobes stay up across back-to-back accesses of one kind; idle or an access of the other kind drops them
    task tick_n(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        rd <= 1'b0;
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask

    task rd_chk(input logic [3:0] a, input logic [7:0] x, input logic [7:0] m);
        exp_q.push_back({m, x & m});
        wr <= 1'b0;
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
    endtask

    task wait_lvl(input int w, input logic v, input int bound);
        int k;
        tick_n(1);
        for (k = 0; k < bound && reqs[w] !== v; k++)
            @(posedge clk);
        if (reqs[w] !== v)
        begin
            err_total++;
            $display("mismatch req %0d expected %b seen %b", w, v, reqs[w]);
            conclude();
        end
    endtask

    // packed: mode, ctrl, low, high, low exp, low mask, high exp, high mask
    task tcase(input logic [3:0] b, input logic g, input logic [63:0] v);
        ext_irq_a_pin <= g;
        wr_reg(b, v[47:40]);
        wr_reg(b + 4'h1, v[39:32]);
        wr_reg(MDE, v[63:56]);
        wr_reg(CTL, v[55:48]);
        tick_n(12);
        wr_reg(CTL, 8'h00);
        rd_chk(b, v[31:24], v[23:16]);
        rd_chk(b + 4'h1, v[15:8], v[7:0]);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // results appear the cycle after the read strobe
    always @(posedge clk)
    begin
        if (rd_seen)
        begin
            if (exp_q.size() == 0)
            begin
                err_total++;
                $display("mismatch rdata expected none seen %h", rdata);
            end
            else
            begin
                e = exp_q.pop_front();
                cmp("rdata", e[7:0], rdata & e[15:8]);
            end
        end
        rd_seen = rd;
    end

    initial
    begin
        {wr, rd, en, slow, rd_seen} = 5'h00;
        {addr, wdata} = 12'h000;
        {unit_a_event_pin, unit_b_event_pin} = 2'h3;
        {ext_irq_a_pin, ext_irq_b_pin} = 2'h3;
        arst_n = 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 8; i++)
            rd_chk(4'(i), 8'h00, 8'hFF);
        wr_reg(4'hC, 8'hA5);
        rd_chk(4'hC, 8'h00, 8'hFF);
        seed = xs(seed);
        wr_reg(MDE, seed[7:0]);
        rd_chk(MDE, seed[7:0], 8'hFF);
        tcase(4'h2, 1'b1, 64'h00101F12001E13FF);
        tcase(4'h2, 1'b1, 64'h0110FF1200FE13FF);
        tcase(4'h2, 1'b1, 64'h0210FF1212FE12FF);
        tcase(4'h2, 1'b0, 64'h0910401240FF12FF);
        tcase(4'h2, 1'b1, 64'h0910FF1200FE13FF);
        tcase(4'h4, 1'b1, 64'h1040FF1200FE13FF);
        seed = xs(seed);
        tcase(4'h4, 1'b1, {16'h3040, seed[15:0], seed[15:8], 8'hFF,
            seed[7:0], 8'hFF});
        tcase(4'h2, 1'b1, 64'h034055FF55FF00FE);
        tcase(4'h2, 1'b1, 64'h0510401240FF12FF);
        wr_reg(4'h2, 8'h00);
        wr_reg(CTL, 8'h10);
        tick_n(14);
        unit_a_event_pin <= 1'b0;
        tick_n(30);
        wr_reg(CTL, 8'h00);
        rd_chk(4'h2, 8'h01, 8'hFF);
        unit_a_event_pin <= 1'b1;
        wr_reg(MSK, 8'h01);
        wr_reg(4'h2, 8'hFF);
        wr_reg(4'h3, 8'hFF);
        wr_reg(MDE, 8'h01);
        wr_reg(CTL, 8'h10);
        wait_lvl(0, 1'b1, 40);
        cmp("irq", 8'h01, {7'h00, irq});
        rd_chk(CTL, 8'h30, 8'hF0);
        wr_reg(MSK, 8'h00);
        tick_n(3);
        cmp("irq", 8'h00, {7'h00, irq});
        wr_reg(MSK, 8'h01);
        tick_n(3);
        cmp("irq", 8'h01, {7'h00, irq});
        rd_chk(STS, 8'h01, 8'h01);
        tick_n(3);
        cmp("irq", 8'h00, {7'h00, irq});
        rd_chk(STS, 8'h00, 8'h01);
        en <= 1'b1;
        wait_lvl(0, 1'b0, 40);
        en <= 1'b0;
        rd_chk(CTL, 8'h10, 8'hF0);
        wr_reg(CTL, 8'h01);
        ext_irq_a_pin <= 1'b0;
        wait_lvl(2, 1'b1, 40);
        rd_chk(STS, 8'h04, 8'h04);
        {slow, en} <= 2'h3;
        wait_lvl(2, 1'b0, 40);
        en <= 1'b0;
        tick_n(40);
        cmp("req_ext_a", 8'h00, {7'h00, req_ext_a});
        wr_reg(CTL, 8'h00);
        wait_lvl(2, 1'b1, 40);
        ext_irq_a_pin <= 1'b1;
        en <= 1'b1;
        wait_lvl(2, 1'b0, 40);
        en <= 1'b0;
        // unit b reload overflow and a low level on its interrupt pin
        wr_reg(4'h4, 8'hFF);
        wr_reg(MDE, 8'h20);
        wr_reg(CTL, 8'h40);
        ext_irq_b_pin <= 1'b0;
        wait_lvl(1, 1'b1, 40);
        wait_lvl(3, 1'b1, 40);
        rd_chk(STS, 8'h0A, 8'h0A);
        tick_n(4);
        conclude();
    end
endmodule
